// ==== core/eqc_coef_access.sv ====
`timescale 1ns/1ps
`default_nettype none

module eqc_coef_access
	import eqc_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// codec link 16-bit register port
	input  wire logic              wordWrite,
	input  wire logic              wordRead,
	input  wire logic [7:0]        wordAddr,
	input  wire logic [15:0]       wordWdata,
	output logic      [15:0]       wordRdata,
	// two-wire bus byte register port
	input  wire logic              byteWrite,
	input  wire logic              byteRead,
	input  wire logic [7:0]        byteAddr,
	input  wire logic [7:0]        byteWdata,
	output logic      [7:0]        byteRdata,
	// input configuration
	input  wire logic              sixChannelMode,
	// coefficient fetch by the filter engine
	input  wire eqc_pkg::eqc_index_type dspIndex,
	output eqc_pkg::eqc_coef_type  dspCoef,
	// path control to the filter engine
	output logic                   staticEqEnable,
	output logic                   sideFiringEnable,
	output logic [5:0]             redirectChannelMask
);
	import eqc_pkg::*;

	logic [15:0]   eqSideCtrl;
	logic [15:0]   bassCtrl;
	logic [15:0]   dataLow;
	logic [7:0]    accessLoc;
	logic          accessRw;
	logic [3:0]    dataHigh;
	eqc_coef_type  coefMem [COEF_WORDS];

	logic          trigger;
	logic [7:0]    next_loc;
	logic          next_rw;
	logic [3:0]    next_high;
	logic          locValid;
	eqc_index_type locIndex;
	logic          memWrite;
	logic          memRead;

	function automatic eqc_coef_type coefDefault(input int idx);
		if (idx == SBW_BASE || idx == SBW_BASE + 4) begin
			coefDefault = SBW_B2_RESET;
		end else if (idx == SBW_BASE + 1) begin
			coefDefault = SBW_B0_RESET;
		end else if (idx == SBW_BASE + 2) begin
			coefDefault = SBW_A2_RESET;
		end else if (idx == SBW_BASE + 3) begin
			coefDefault = SBW_A1_RESET;
		end else if (idx >= SCALE_IN_BASE && idx < REDIR_BASE) begin
			coefDefault = SCALE_FULL_RESET;
		end else if (idx == LFE_REDIR_IDX) begin
			coefDefault = SCALE_FULL_RESET;
		end else if (idx >= REDIR_BASE) begin
			coefDefault = SCALE_HALF_RESET;
		end else begin
			coefDefault = COEF_ZERO;
		end
	endfunction

	// byte lane of a 16-bit register: even address is the high byte
	function automatic logic [7:0] laneOf(input logic [15:0] w, input logic [7:0] a);
		laneOf = a[0] ? w[7:0] : w[15:8];
	endfunction

	// a transfer fires on a word write to 7Ah or a byte write to 7Bh
	always_comb begin
		trigger   = 1'b0;
		next_loc  = accessLoc;
		next_rw   = accessRw;
		next_high = dataHigh;
		if (wordWrite && wordAddr == REG_ACCESS) begin
			trigger   = 1'b1;
			next_loc  = wordWdata[15:8];
			next_rw   = wordWdata[RW_BIT];
			next_high = wordWdata[3:0];
		end else if (byteWrite && !wordWrite && byteAddr == REG_ACCESS_B) begin
			trigger   = 1'b1;
			next_rw   = byteWdata[RW_BIT];
			next_high = byteWdata[3:0];
		end
	end

	// locations outside 40h..84h are ignored, so a stray write cannot land anywhere
	assign locValid = (next_loc >= COEF_BASE_LOC) &&
		(next_loc < COEF_BASE_LOC + 8'(COEF_WORDS));
	assign locIndex = 7'(next_loc - COEF_BASE_LOC);
	assign memWrite = trigger && locValid && (next_rw != RW_READ);
	assign memRead  = trigger && locValid && (next_rw == RW_READ);

	// path control registers; the word port wins a same-cycle clash
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			eqSideCtrl <= CTRL_RESET;
			bassCtrl   <= CTRL_RESET;
		end else if (wordWrite) begin
			if (wordAddr == REG_EQ_SIDE) begin
				eqSideCtrl <= wordWdata;
			end else if (wordAddr == REG_BASS) begin
				bassCtrl <= wordWdata;
			end
		end else if (byteWrite) begin
			if (byteAddr == REG_EQ_SIDE) begin
				eqSideCtrl[15:8] <= byteWdata;
			end else if (byteAddr == REG_EQ_SIDE + 8'h01) begin
				eqSideCtrl[7:0] <= byteWdata;
			end else if (byteAddr == REG_BASS) begin
				bassCtrl[15:8] <= byteWdata;
			end else if (byteAddr == REG_BASS + 8'h01) begin
				bassCtrl[7:0] <= byteWdata;
			end
		end
	end

	// access control register and data window
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dataLow   <= CTRL_RESET;
			accessLoc <= 8'h00;
			accessRw  <= 1'b0;
			dataHigh  <= 4'h0;
		end else begin
			if (trigger) begin
				accessLoc <= next_loc;
				accessRw  <= next_rw;
			end else if (byteWrite && !wordWrite && byteAddr == REG_ACCESS) begin
				accessLoc <= byteWdata;
			end
			if (memRead) begin
				// result lands on the same edge, ready for the very next access
				dataLow  <= coefMem[locIndex][15:0];
				dataHigh <= coefMem[locIndex][19:16];
			end else begin
				// a read that misses the memory must not leave its own nibble behind
				if (trigger && next_rw != RW_READ) begin
					dataHigh <= next_high;
				end
				if (wordWrite && wordAddr == REG_DATA_LOW) begin
					dataLow <= wordWdata;
				end else if (!wordWrite && byteWrite && byteAddr == REG_DATA_LOW) begin
					dataLow[15:8] <= byteWdata;
				end else if (!wordWrite && byteWrite && byteAddr == REG_DATA_LOW_B) begin
					dataLow[7:0] <= byteWdata;
				end
			end
		end
	end

	// coefficient memory; only a write transfer stores a word
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < COEF_WORDS; i++) begin
				coefMem[i] <= coefDefault(i);
			end
		end else if (memWrite) begin
			coefMem[locIndex] <= {next_high, dataLow};
		end
	end

	// register reads; unmapped addresses answer zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wordRdata <= 16'h0000;
			byteRdata <= 8'h00;
		end else begin
			if (wordRead) begin
				if (wordAddr == REG_EQ_SIDE) begin
					wordRdata <= eqSideCtrl;
				end else if (wordAddr == REG_BASS) begin
					wordRdata <= bassCtrl;
				end else if (wordAddr == REG_DATA_LOW) begin
					wordRdata <= dataLow;
				end else if (wordAddr == REG_ACCESS) begin
					wordRdata <= {accessLoc, accessRw, 3'h0, dataHigh};
				end else begin
					wordRdata <= 16'h0000;
				end
			end
			if (byteRead) begin
				if (byteAddr[7:1] == REG_EQ_SIDE[7:1]) begin
					byteRdata <= laneOf(eqSideCtrl, byteAddr);
				end else if (byteAddr[7:1] == REG_BASS[7:1]) begin
					byteRdata <= laneOf(bassCtrl, byteAddr);
				end else if (byteAddr[7:1] == REG_DATA_LOW[7:1]) begin
					byteRdata <= laneOf(dataLow, byteAddr);
				end else if (byteAddr[7:1] == REG_ACCESS[7:1]) begin
					byteRdata <= laneOf({accessLoc, accessRw, 3'h0, dataHigh}, byteAddr);
				end else begin
					byteRdata <= 8'h00;
				end
			end
		end
	end

	// filter engine fetch: sets laid out as LR, surround, subwoofer,
	// four stages of five words each, then scale-in and redirection factors
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dspCoef <= COEF_ZERO;
		end else if (dspIndex < 7'(COEF_WORDS)) begin
			dspCoef <= coefMem[dspIndex];
		end else begin
			dspCoef <= COEF_ZERO;
		end
	end

	// channel order of the mask: L, R, LS, RS, C, LFE
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			staticEqEnable      <= 1'b0;
			sideFiringEnable    <= 1'b0;
			redirectChannelMask <= 6'h00;
		end else begin
			staticEqEnable   <= eqSideCtrl[EQ_EN_BIT];
			sideFiringEnable <= eqSideCtrl[SIDE_EN_BIT];
			if (!bassCtrl[REDIR_EN_BIT]) begin
				redirectChannelMask <= 6'h00;
			end else begin
				redirectChannelMask <= {sixChannelMode, sixChannelMode, 4'hF};
			end
		end
	end

	a_read_latch: assert property (@(posedge clk) disable iff (sys_rst)
		memRead |=> dataLow == $past(coefMem[locIndex][15:0])
			&& dataHigh == $past(coefMem[locIndex][19:16]))
		else $error("read result not latched into data registers");

	a_write_store: assert property (@(posedge clk) disable iff (sys_rst)
		memWrite |=> coefMem[$past(locIndex)] == {$past(next_high), $past(dataLow)})
		else $error("write transfer did not store the coefficient");

	a_low_only: assert property (@(posedge clk) disable iff (sys_rst)
		(wordWrite && wordAddr == REG_DATA_LOW)
			|=> coefMem[$past(locIndex)] == $past(coefMem[locIndex]))
		else $error("data-low write touched coefficient memory");

	a_word_loc: assert property (@(posedge clk) disable iff (sys_rst)
		(wordWrite && wordAddr == REG_ACCESS) |=> accessLoc == $past(wordWdata[15:8]))
		else $error("location not taken from high byte");

	a_byte_lanes: assert property (@(posedge clk) disable iff (sys_rst)
		(byteRead && byteAddr == REG_DATA_LOW_B) |=> byteRdata == $past(dataLow[7:0]))
		else $error("byte 79h does not show lowest eight bits");

	a_redir_gate: assert property (@(posedge clk) disable iff (sys_rst)
		!bassCtrl[REDIR_EN_BIT] |=> redirectChannelMask == 6'h00)
		else $error("redirection active while disabled");

	a_six_channel: assert property (@(posedge clk) disable iff (sys_rst)
		(!sixChannelMode && bassCtrl[REDIR_EN_BIT]) |=> redirectChannelMask == 6'h0F)
		else $error("centre or LFE redirected without six-channel input");

	a_eq_paths: assert property (@(posedge clk) disable iff (sys_rst)
		##1 staticEqEnable == $past(eqSideCtrl[EQ_EN_BIT])
			&& sideFiringEnable == $past(eqSideCtrl[SIDE_EN_BIT]))
		else $error("path enables do not follow register 70h");

	a_high_nibble: assert property (@(posedge clk) disable iff (sys_rst)
		(wordRead && wordAddr == REG_ACCESS) |=> wordRdata[3:0] == $past(dataHigh))
		else $error("upper coefficient bits not in low nibble");

	a_dsp_fetch: assert property (@(posedge clk) disable iff (sys_rst)
		(dspIndex < 7'(COEF_WORDS)) |=> dspCoef == $past(coefMem[dspIndex]))
		else $error("filter fetch does not return the addressed word");

	a_byte_loc: assert property (@(posedge clk) disable iff (sys_rst)
		(byteWrite && !wordWrite && byteAddr == REG_ACCESS) |=> accessLoc == $past(byteWdata))
		else $error("byte location write not stored");

	a_bad_loc: assert property (@(posedge clk) disable iff (sys_rst)
		(trigger && !locValid) |=> $stable(dataLow))
		else $error("transfer outside the coefficient memory changed the data register");
endmodule

`default_nettype wire

// ==== core/eqc_pkg.sv ====
package eqc_pkg;
	// register offsets, word view and byte view
	localparam logic [7:0]  REG_EQ_SIDE      = 8'h70;
	localparam logic [7:0]  REG_BASS         = 8'h72;
	localparam logic [7:0]  REG_DATA_LOW     = 8'h78;
	localparam logic [7:0]  REG_DATA_LOW_B   = 8'h79;
	localparam logic [7:0]  REG_ACCESS       = 8'h7A;
	localparam logic [7:0]  REG_ACCESS_B     = 8'h7B;
	// coefficient memory
	localparam logic [11:0] COEF_RAM_LOC     = 12'h240;
	localparam logic [7:0]  COEF_BASE_LOC    = 8'h40;
	localparam int          COEF_WORDS       = 69;
	localparam int          COEF_WIDTH       = 20;
	localparam int          STAGES           = 4;
	localparam int          WORDS_PER_STAGE  = 5;
	localparam int          LR_BASE          = 0;
	localparam int          SUR_BASE         = 20;
	localparam int          SBW_BASE         = 40;
	localparam int          SCALE_IN_BASE    = 60;
	localparam int          REDIR_BASE       = 63;
	// field positions
	localparam int          EQ_EN_BIT        = 0;
	localparam int          SIDE_EN_BIT      = 1;
	localparam int          REDIR_EN_BIT     = 0;
	localparam int          RW_BIT           = 7;
	localparam logic        RW_READ          = 1'b1;
	// reset values
	localparam logic [15:0] CTRL_RESET       = 16'h0000;
	localparam logic [19:0] COEF_ZERO        = 20'h00000;
	localparam logic [19:0] SBW_B2_RESET     = 20'h00032;
	localparam logic [19:0] SBW_B0_RESET     = 20'h80032;
	localparam logic [19:0] SBW_A2_RESET     = 20'h7C7EA;
	localparam logic [19:0] SBW_A1_RESET     = 20'h81C6F;
	localparam logic [19:0] SCALE_FULL_RESET = 20'h80000;
	localparam logic [19:0] SCALE_HALF_RESET = 20'hC0000;
	localparam int          LFE_REDIR_IDX    = 68;

	typedef logic [6:0]  eqc_index_type;
	typedef logic [19:0] eqc_coef_type;
endpackage

// ==== tb/eqc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module eqc_host_model
	import eqc_pkg::*;
(
	// clock
	input  wire logic        clk,
	// codec link side
	output logic             wordWrite,
	output logic             wordRead,
	output logic [7:0]       wordAddr,
	output logic [15:0]      wordWdata,
	// two-wire side
	output logic             byteWrite,
	output logic             byteRead,
	output logic [7:0]       byteAddr,
	output logic [7:0]       byteWdata
);
	initial begin
		{wordWrite, wordRead, byteWrite, byteRead} = 4'h0;
		wordAddr = 8'h00;
		wordWdata = 16'h0000;
		byteAddr = 8'h00;
		byteWdata = 8'h00;
	end

	function automatic logic [7:0] loc(input eqc_index_type i);
		return {1'b0, i} + COEF_BASE_LOC;
	endfunction

	// one access, one-cycle strobe; data lines toggle once released so no stale value lingers
	task automatic acc(input logic w, rd, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		if (w) begin
			wordWrite <= !rd;
			wordRead <= rd;
			wordAddr <= a;
			wordWdata <= d;
		end else begin
			byteWrite <= !rd;
			byteRead <= rd;
			byteAddr <= a;
			byteWdata <= d[7:0];
		end
		@(posedge clk);
		{wordWrite, wordRead, byteWrite, byteRead} <= 4'h0;
		wordWdata <= ~wordWdata;
		byteWdata <= ~byteWdata;
	endtask

	task automatic wWr(input eqc_index_type i, input eqc_coef_type v);
		acc(1'b1, 1'b0, REG_DATA_LOW, v[15:0]);
		acc(1'b1, 1'b0, REG_ACCESS, {loc(i), ~RW_READ, 3'h0, v[19:16]});
	endtask

	task automatic wRd(input eqc_index_type i);
		acc(1'b1, 1'b0, REG_ACCESS, {loc(i), RW_READ, 7'h00});
		acc(1'b1, 1'b1, REG_DATA_LOW, 16'h0000);
		acc(1'b1, 1'b1, REG_ACCESS, 16'h0000);
	endtask

	task automatic bWr(input eqc_index_type i, input eqc_coef_type v);
		acc(1'b0, 1'b0, REG_DATA_LOW, {8'h00, v[15:8]});
		acc(1'b0, 1'b0, REG_DATA_LOW_B, {8'h00, v[7:0]});
		acc(1'b0, 1'b0, REG_ACCESS, {8'h00, loc(i)});
		acc(1'b0, 1'b0, REG_ACCESS_B, {8'h00, ~RW_READ, 3'h0, v[19:16]});
	endtask

	task automatic bRd(input eqc_index_type i);
		acc(1'b0, 1'b0, REG_ACCESS, {8'h00, loc(i)});
		acc(1'b0, 1'b0, REG_ACCESS_B, {8'h00, RW_READ, 7'h00});
		acc(1'b0, 1'b1, REG_DATA_LOW, 16'h0000);
		acc(1'b0, 1'b1, REG_DATA_LOW_B, 16'h0000);
		acc(1'b0, 1'b1, REG_ACCESS_B, 16'h0000);
	endtask
endmodule

`default_nettype wire

// ==== tb/eqc_coef_access_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module eqc_coef_access_tb;
	import eqc_pkg::*;
	logic          clk;
	logic          sys_rst;
	logic          sixChannelMode;
	eqc_index_type dspIndex;
	wire logic     wordWrite, wordRead, byteWrite, byteRead;
	wire logic [7:0]  wordAddr, byteAddr, byteWdata;
	wire logic [15:0] wordWdata;
	logic [15:0]   wordRdata;
	logic [7:0]    byteRdata;
	eqc_coef_type  dspCoef;
	logic          staticEqEnable, sideFiringEnable;
	logic [5:0]    redirectChannelMask;
	int            n_errors = 0;
	int            comparisons = 0;
	logic [15:0]   expQ [$];
	logic          wPend = 1'b0;
	logic          bPend = 1'b0;
	eqc_index_type ixs [8] = '{7'h00, 7'h13, 7'h14, 7'h27, 7'h28, 7'h3B, 7'h3E, 7'h44};
	eqc_index_type dIx [6] = '{7'h00, 7'h28, 7'h29, 7'h2B, 7'h3C, 7'h3F};
	eqc_coef_type  dVal [6] = '{COEF_ZERO, SBW_B2_RESET, SBW_B0_RESET, SBW_A1_RESET,
		SCALE_FULL_RESET, SCALE_HALF_RESET};
	logic [7:0]    rAd [6] = '{REG_EQ_SIDE, REG_BASS, REG_DATA_LOW, REG_ACCESS, 8'h74, 8'h79};

	eqc_host_model HOST (.clk(clk), .wordWrite(wordWrite), .wordRead(wordRead),
		.wordAddr(wordAddr), .wordWdata(wordWdata), .byteWrite(byteWrite),
		.byteRead(byteRead), .byteAddr(byteAddr), .byteWdata(byteWdata));
	eqc_coef_access DUT (.clk(clk), .sys_rst(sys_rst), .wordWrite(wordWrite),
		.wordRead(wordRead), .wordAddr(wordAddr), .wordWdata(wordWdata),
		.wordRdata(wordRdata), .byteWrite(byteWrite), .byteRead(byteRead),
		.byteAddr(byteAddr), .byteWdata(byteWdata), .byteRdata(byteRdata),
		.sixChannelMode(sixChannelMode), .dspIndex(dspIndex), .dspCoef(dspCoef),
		.staticEqEnable(staticEqEnable), .sideFiringEnable(sideFiringEnable),
		.redirectChannelMask(redirectChannelMask));

	always #12.5 clk = ~clk;

	task automatic check(input logic [19:0] got, exp, input string m);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t ns: %s got %h want %h", $time, m, got, exp);
		end
	endtask

	task automatic take(input logic [15:0] got);
		if (expQ.size() == 0) check(20'h00001, 20'h00000, "unexpected read answer");
		else check({4'h0, got}, {4'h0, expQ.pop_front()}, "read answer");
	endtask

	// answers settle one edge after the strobe is sampled, so look at the falling edge
	always @(negedge clk) begin
		if (wPend) take(wordRdata);
		if (bPend) take({8'h00, byteRdata});
		wPend = wordRead;
		bPend = byteRead;
	end

	task automatic dsp(input eqc_index_type i, input eqc_coef_type e);
		@(posedge clk);
		dspIndex <= i;
		repeat (2) @(posedge clk);
		@(negedge clk);
		check(dspCoef, e, "coefficient fetch");
	endtask

	task automatic flags(input logic [7:0] e);
		repeat (2) @(posedge clk);
		@(negedge clk);
		check({12'h000, redirectChannelMask, sideFiringEnable, staticEqEnable},
			{12'h000, e}, "path control");
	endtask

	task automatic complete_run;
		if (expQ.size() != 0) begin
			n_errors++;
			$display("[FAIL] %0t ns: %0d read answers never arrived", $time, expQ.size());
		end
		$display("comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		n_errors++;
		$display("[FAIL] %0t ns: run did not finish in time", $time);
		complete_run;
	end

	initial begin
		int unsigned r;
		eqc_coef_type v;
		logic [7:0] lc;
		clk = 1'b0;
		sys_rst = 1'b1;
		sixChannelMode = 1'b0;
		dspIndex = 7'h00;
		r = $urandom(32'h9ddf);
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (dIx[k]) dsp(dIx[k], dVal[k]);
		foreach (rAd[k]) begin
			expQ.push_back(16'h0000);
			HOST.acc(1'b1, 1'b1, rAd[k], 16'h0000);
		end
		flags(8'h00);
		dsp(7'h45, COEF_ZERO);
		$display("test done: reset state");
		foreach (ixs[k]) begin
			for (int b = 0; b < 2; b++) begin
				r = $urandom;
				v = r[19:0];
				// scale words stay negative, filter words take any 20-bit value
				if (ixs[k] >= 7'h3C) v[19] = 1'b1;
				if (b == 0) HOST.wWr(ixs[k], v);
				else HOST.bWr(ixs[k], v);
				dsp(ixs[k], v);
				HOST.acc(1'b1, 1'b0, REG_DATA_LOW, ~v[15:0]);
				dsp(ixs[k], v);
				lc = {1'b0, ixs[k]} + COEF_BASE_LOC;
				if (b == 0) begin
					expQ.push_back(v[15:0]);
					expQ.push_back({lc, RW_READ, 3'h0, v[19:16]});
					HOST.wRd(ixs[k]);
				end else begin
					expQ.push_back({8'h00, v[15:8]});
					expQ.push_back({8'h00, v[7:0]});
					expQ.push_back({8'h00, RW_READ, 3'h0, v[19:16]});
					HOST.bRd(ixs[k]);
				end
			end
		end
		// a location past the last word must leave the memory alone
		HOST.wWr(7'h45, 20'h12345);
		dsp(ixs[7], v);
		$display("test done: coefficient transfers");
		for (int m = 0; m < 4; m++) begin
			HOST.acc(1'b1, 1'b0, REG_EQ_SIDE, 16'(m));
			flags({6'h00, m[1:0]});
		end
		for (int m = 0; m < 4; m++) begin
			@(posedge clk);
			sixChannelMode <= m[1];
			HOST.acc(1'b0, 1'b0, 8'h73, {15'h0000, m[0]});
			flags({m[0] ? (m[1] ? 6'h3F : 6'h0F) : 6'h00, 2'h3});
		end
		expQ.push_back(16'h0001);
		HOST.acc(1'b0, 1'b1, 8'h73, 16'h0000);
		expQ.push_back(16'h0001);
		HOST.acc(1'b1, 1'b1, REG_BASS, 16'h0000);
		$display("test done: path control");
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		dsp(7'h44, SCALE_FULL_RESET);
		dsp(7'h00, COEF_ZERO);
		flags(8'h00);
		$display("test done: reset in mid-run");
		complete_run;
	end
endmodule

`default_nettype wire
